// ### design/iwb_top.sv
// Purpose: Register driven two-wire master that runs one short frame at a time
// Assumes: SFR port is synchronous; pins are open drain, resolved outside
// Notes: Completion interrupt feeds external interrupt input 6
`timescale 1ns/100ps
module iwb_top (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // Special function register port
   input wire logic [15:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   // Interrupt toward external input 6
   output logic o_ext_irq6,
   // Two-wire pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_scl_oe_n,
   output logic o_sda,
   output logic o_sda_oe_n
);
   import iwb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   logic rst_s1_reg, rst_n;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   iwb_bit_if bit_if ();

   // Open drain: only ever drive low, SCL input is not used (no stretching)
   assign o_scl = 1'b0;
   assign o_sda = 1'b0;

   iwb_line_drv u_drv (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_ce(i_ce),
      .bus(bit_if.drv),
      .i_sda(i_sda),
      .o_scl_oe_n(o_scl_oe_n),
      .o_sda_oe_n(o_sda_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register and sequencer state
   logic [7:0] target_address_reg, target_address_next;
   logic [7:0] tx_first_byte_reg, tx_first_byte_next;
   logic [7:0] tx_second_byte_reg, tx_second_byte_next;
   logic [7:0] rx_first_byte_reg, rx_first_byte_next;
   logic [7:0] rx_second_byte_reg, rx_second_byte_next;
   logic two_byte_select_reg, two_byte_select_next;
   logic transfer_go_busy_reg, transfer_go_busy_next;
   logic ack_error_flag_reg, ack_error_flag_next;
   logic twowire_irq_enable_reg, twowire_irq_enable_next;
   logic twowire_irq_flag_reg, twowire_irq_flag_next;
   iwb_state_e state_reg, state_next;
   logic cmd_valid_reg, cmd_valid_next;
   iwb_cmd_e cmd_reg, cmd_next;
   logic [7:0] tx_byte_reg, tx_byte_next;
   logic ack_bit_reg, ack_bit_next;
   logic [7:0] rdata_reg, rdata_next;
   logic go_wr;
   logic is_read;

   // One address compare used by every register write
   function automatic logic hit(input logic [15:0] a);
      return i_sfr_wr && (i_sfr_addr == a);
   endfunction

   // Start request only counts while idle; software must not write while busy
   assign go_wr = hit(ADDR_CTRL) && i_sfr_wdata[BIT_GO] && !transfer_go_busy_reg;
   assign is_read = target_address_reg[BIT_DIR];

   ////////////////////////////////////////////////////////////////////////////
   // Next state: register writes and frame sequencing
   always_comb begin
      target_address_next = target_address_reg;
      tx_first_byte_next = tx_first_byte_reg;
      tx_second_byte_next = tx_second_byte_reg;
      rx_first_byte_next = rx_first_byte_reg;
      rx_second_byte_next = rx_second_byte_reg;
      two_byte_select_next = two_byte_select_reg;
      transfer_go_busy_next = transfer_go_busy_reg;
      ack_error_flag_next = ack_error_flag_reg;
      twowire_irq_enable_next = twowire_irq_enable_reg;
      twowire_irq_flag_next = twowire_irq_flag_reg;
      state_next = state_reg;
      cmd_valid_next = cmd_valid_reg;
      cmd_next = cmd_reg;
      tx_byte_next = tx_byte_reg;
      ack_bit_next = ack_bit_reg;
      // Data registers are locked while busy so the frame sees stable values
      if (!transfer_go_busy_reg) begin
         if (hit(ADDR_TARGET)) target_address_next = i_sfr_wdata;
         if (hit(ADDR_TX_FIRST)) tx_first_byte_next = i_sfr_wdata;
         if (hit(ADDR_TX_SECOND)) tx_second_byte_next = i_sfr_wdata;
         if (hit(ADDR_CTRL)) two_byte_select_next = i_sfr_wdata[BIT_LEN];
      end
      if (hit(ADDR_IRQ6)) begin
         twowire_irq_enable_next = i_sfr_wdata[BIT_IRQ_EN];
         // Flag is cleared by writing zero; a completion event in the same cycle wins
         if (!i_sfr_wdata[BIT_IRQ_FLAG]) twowire_irq_flag_next = 1'b0;
      end
      case (state_reg)
         IWB_ST_IDLE: begin
            if (go_wr) begin
               transfer_go_busy_next = 1'b1;
               ack_error_flag_next = 1'b0;
               twowire_irq_flag_next = 1'b0;
               cmd_valid_next = 1'b1;
               cmd_next = IWB_CMD_START;
               state_next = IWB_ST_START;
            end
         end
         IWB_ST_START: begin
            if (bit_if.cmd_done) begin
               cmd_next = IWB_CMD_WRITE;
               tx_byte_next = target_address_reg;
               state_next = IWB_ST_ADDR;
            end
         end
         IWB_ST_ADDR: begin
            if (bit_if.cmd_done) begin
               if (bit_if.rx_ack_bit) begin
                  ack_error_flag_next = 1'b1;
                  cmd_next = IWB_CMD_STOP;
                  state_next = IWB_ST_STOP;
               end else begin
                  cmd_next = is_read ? IWB_CMD_READ : IWB_CMD_WRITE;
                  tx_byte_next = tx_first_byte_reg;
                  // Master nacks the last read byte
                  ack_bit_next = !two_byte_select_reg;
                  state_next = IWB_ST_DATA1;
               end
            end
         end
         IWB_ST_DATA1: begin
            if (bit_if.cmd_done) begin
               if (is_read) rx_first_byte_next = bit_if.rx_byte;
               if (!is_read && bit_if.rx_ack_bit) ack_error_flag_next = 1'b1;
               if (two_byte_select_reg && !(!is_read && bit_if.rx_ack_bit)) begin
                  tx_byte_next = tx_second_byte_reg;
                  ack_bit_next = 1'b1;
                  state_next = IWB_ST_DATA2;
               end else begin
                  cmd_next = IWB_CMD_STOP;
                  state_next = IWB_ST_STOP;
               end
            end
         end
         IWB_ST_DATA2: begin
            if (bit_if.cmd_done) begin
               if (is_read) rx_second_byte_next = bit_if.rx_byte;
               if (!is_read && bit_if.rx_ack_bit) ack_error_flag_next = 1'b1;
               cmd_next = IWB_CMD_STOP;
               state_next = IWB_ST_STOP;
            end
         end
         IWB_ST_STOP: begin
            if (bit_if.cmd_done) begin
               cmd_valid_next = 1'b0;
               state_next = IWB_ST_DONE;
            end
         end
         IWB_ST_DONE: begin
            transfer_go_busy_next = 1'b0;
            twowire_irq_flag_next = 1'b1;
            state_next = IWB_ST_IDLE;
         end
         default: state_next = IWB_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         target_address_reg <= RST_BYTE;
         tx_first_byte_reg <= RST_BYTE;
         tx_second_byte_reg <= RST_BYTE;
         rx_first_byte_reg <= RST_BYTE;
         rx_second_byte_reg <= RST_BYTE;
         two_byte_select_reg <= 1'b0;
         transfer_go_busy_reg <= 1'b0;
         ack_error_flag_reg <= 1'b0;
         twowire_irq_enable_reg <= 1'b0;
         twowire_irq_flag_reg <= 1'b0;
         state_reg <= IWB_ST_IDLE;
         cmd_valid_reg <= 1'b0;
         cmd_reg <= IWB_CMD_START;
         tx_byte_reg <= RST_BYTE;
         ack_bit_reg <= 1'b1;
         rdata_reg <= RST_BYTE;
      end else if (i_ce) begin
         target_address_reg <= target_address_next;
         tx_first_byte_reg <= tx_first_byte_next;
         tx_second_byte_reg <= tx_second_byte_next;
         rx_first_byte_reg <= rx_first_byte_next;
         rx_second_byte_reg <= rx_second_byte_next;
         two_byte_select_reg <= two_byte_select_next;
         transfer_go_busy_reg <= transfer_go_busy_next;
         ack_error_flag_reg <= ack_error_flag_next;
         twowire_irq_enable_reg <= twowire_irq_enable_next;
         twowire_irq_flag_reg <= twowire_irq_flag_next;
         state_reg <= state_next;
         cmd_valid_reg <= cmd_valid_next;
         cmd_reg <= cmd_next;
         tx_byte_reg <= tx_byte_next;
         ack_bit_reg <= ack_bit_next;
         rdata_reg <= rdata_next;
      end
   end

   assign bit_if.cmd_valid = cmd_valid_reg;
   assign bit_if.cmd = cmd_reg;
   assign bit_if.tx_byte = tx_byte_reg;
   assign bit_if.tx_ack_bit = ack_bit_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux, registered; unmapped addresses read zero
   always_comb begin
      rdata_next = RST_BYTE;
      case (i_sfr_addr)
         ADDR_TARGET: rdata_next = target_address_reg;
         ADDR_TX_FIRST: rdata_next = tx_first_byte_reg;
         ADDR_TX_SECOND: rdata_next = tx_second_byte_reg;
         ADDR_RX_FIRST: rdata_next = rx_first_byte_reg;
         ADDR_RX_SECOND: rdata_next = rx_second_byte_reg;
         ADDR_CTRL: begin
            rdata_next[BIT_LEN] = two_byte_select_reg;
            rdata_next[BIT_GO] = transfer_go_busy_reg;
            rdata_next[BIT_ACK_ERR] = ack_error_flag_reg;
         end
         ADDR_IRQ6: begin
            rdata_next[BIT_IRQ_EN] = twowire_irq_enable_reg;
            rdata_next[BIT_IRQ_FLAG] = twowire_irq_flag_reg;
         end
         default: rdata_next = RST_BYTE;
      endcase
   end

   assign o_sfr_rdata = rdata_reg;
   // Interrupt line is the gated flag, a level until restart or clear
   assign o_ext_irq6 = twowire_irq_flag_reg & twowire_irq_enable_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_start_sets_busy: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      i_ce && go_wr |=> transfer_go_busy_reg && !twowire_irq_flag_reg)
      else $error("start did not set busy");
   a_start_clears_err: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      i_ce && go_wr |=> !ack_error_flag_reg)
      else $error("error bit not cleared by start");
   a_done_raises_irq: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      i_ce && state_reg == IWB_ST_DONE |=> twowire_irq_flag_reg && !transfer_go_busy_reg)
      else $error("completion did not flag");
   // Masking must silence the line at once, even with the flag still pending
   a_irq_gated_enable: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      i_ce && i_sfr_wr && i_sfr_addr == ADDR_IRQ6 && !i_sfr_wdata[BIT_IRQ_EN]
      |=> !o_ext_irq6)
      else $error("interrupt without enable");
   a_busy_until_idle: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_reg != IWB_ST_IDLE |-> transfer_go_busy_reg)
      else $error("busy dropped mid frame");
   a_addr_nack_stop: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      i_ce && state_reg == IWB_ST_ADDR && bit_if.cmd_done && bit_if.rx_ack_bit
      |=> state_reg == IWB_ST_STOP && ack_error_flag_reg)
      else $error("address nack not handled");
   a_addr_byte_sent: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_reg == IWB_ST_ADDR |-> tx_byte_reg == target_address_reg)
      else $error("address byte mismatch");
   a_last_read_nack: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_reg == IWB_ST_DATA2 || (state_reg == IWB_ST_DATA1 && !two_byte_select_reg)
      |-> ack_bit_reg)
      else $error("last read byte acked");
   a_two_byte_path: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_reg == IWB_ST_DATA2 |-> two_byte_select_reg && tx_byte_reg == tx_second_byte_reg)
      else $error("second byte path wrong");
   c_write_done: cover property (@(posedge i_ref_clk) state_reg == IWB_ST_DONE && !is_read);
   c_read_two: cover property (@(posedge i_ref_clk)
      state_reg == IWB_ST_DATA2 && is_read ##1 state_reg == IWB_ST_DATA2);
   c_addr_nack: cover property (@(posedge i_ref_clk) ack_error_flag_reg && o_ext_irq6);
endmodule

// ### design/iwb_pkg.sv
// Purpose: Shared constants and types for the two-wire master byte engine
// Assumes: 50 MHz system clock, 8-bit special function register port
// Notes: Register addresses are the byte addresses of the SFR space
package iwb_pkg;
   // Register addresses
   localparam logic [15:0] ADDR_TARGET = 16'hFF80;
   localparam logic [15:0] ADDR_TX_FIRST = 16'hFF81;
   localparam logic [15:0] ADDR_TX_SECOND = 16'hFF82;
   localparam logic [15:0] ADDR_RX_FIRST = 16'hFF83;
   localparam logic [15:0] ADDR_RX_SECOND = 16'hFF84;
   localparam logic [15:0] ADDR_CTRL = 16'hFF85;
   localparam logic [15:0] ADDR_IRQ6 = 16'hFF95;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Field positions
   localparam int BIT_DIR = 0;
   localparam int BIT_LEN = 0;
   localparam int BIT_GO = 1;
   localparam int BIT_ACK_ERR = 2;
   localparam int BIT_IRQ_FLAG = 2;
   localparam int BIT_IRQ_EN = 3;
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int SCL_HZ = 400_000;
   // Quarter period of SCL in system clocks, rounded down so the rate never drops below spec
   localparam int QTR_CYC = CLK_HZ / (SCL_HZ * 4);
   localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
   localparam logic [3:0] BITS_LAST = 4'h8;
   // Bit-level commands to the line driver
   typedef enum logic [2:0] {
      IWB_CMD_START = 3'h0,
      IWB_CMD_WRITE = 3'h1,
      IWB_CMD_READ = 3'h2,
      IWB_CMD_STOP = 3'h3
   } iwb_cmd_e;
   // Frame sequencer states, Gray coded from IDLE to DONE along the two byte path
   typedef enum logic [2:0] {
      IWB_ST_IDLE = 3'h0,
      IWB_ST_START = 3'h1,
      IWB_ST_ADDR = 3'h3,
      IWB_ST_DATA1 = 3'h2,
      IWB_ST_DATA2 = 3'h6,
      IWB_ST_STOP = 3'h7,
      IWB_ST_DONE = 3'h5
   } iwb_state_e;
endpackage

// ### design/iwb_bit_if.sv
// Purpose: Carrier between the frame sequencer and the line driver
// Assumes: One clock domain
// Notes: cmd_valid is held for the whole frame, until cmd_done pulses for the stop
`timescale 1ns/100ps
interface iwb_bit_if;
   import iwb_pkg::*;
   logic cmd_valid;
   iwb_cmd_e cmd;
   logic [7:0] tx_byte;
   logic tx_ack_bit;
   logic cmd_done;
   logic [7:0] rx_byte;
   logic rx_ack_bit;
   modport seq (output cmd_valid, cmd, tx_byte, tx_ack_bit, input cmd_done, rx_byte, rx_ack_bit);
   modport drv (input cmd_valid, cmd, tx_byte, tx_ack_bit, output cmd_done, rx_byte, rx_ack_bit);
endinterface

// ### design/iwb_line_drv.sv
// Purpose: Drives SCL and SDA for one start, byte with acknowledge, or stop
// Assumes: Open-drain pins; output enable low means pulling the line low
// Notes: Each bit is four quarter periods; no clock stretching support
`timescale 1ns/100ps
module iwb_line_drv (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Sequencer side
   iwb_bit_if.drv bus,
   // Pins
   input wire logic i_sda,
   output logic o_scl_oe_n,
   output logic o_sda_oe_n
);
   import iwb_pkg::*;

   logic [7:0] qtr_reg, qtr_next;
   logic [1:0] phase_reg, phase_next;
   logic [3:0] bit_reg, bit_next;
   logic [8:0] sh_reg, sh_next;
   logic busy_reg, busy_next;
   logic scl_reg, scl_next;
   logic sda_reg, sda_next;
   logic done;

   ////////////////////////////////////////////////////////////////////////////
   // Bit timing: a quarter counter steps a four phase bit cell
   always_comb begin
      qtr_next = qtr_reg;
      phase_next = phase_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      busy_next = busy_reg;
      scl_next = scl_reg;
      sda_next = sda_reg;
      done = 1'b0;
      if (!busy_reg) begin
         if (bus.cmd_valid) begin
            busy_next = 1'b1;
            qtr_next = '0;
            phase_next = '0;
            bit_next = '0;
            // Read shifts out all ones so the slave owns SDA, then our ack bit
            sh_next = (bus.cmd == IWB_CMD_READ) ? {8'hFF, bus.tx_ack_bit}
                                                : {bus.tx_byte, 1'b1};
         end
      end else if (qtr_reg != QTR_LAST) begin
         qtr_next = qtr_reg + 8'h01;
      end else begin
         qtr_next = '0;
         phase_next = phase_reg + 2'h1;
         case (bus.cmd)
            IWB_CMD_START: begin
               // SDA falls while SCL is high, then SCL falls
               case (phase_reg)
                  2'h0: begin
                     sda_next = 1'b1;
                     scl_next = 1'b1;
                  end
                  2'h1: sda_next = 1'b0;
                  2'h2: scl_next = 1'b0;
                  default: begin
                     busy_next = 1'b0;
                     done = 1'b1;
                  end
               endcase
            end
            IWB_CMD_STOP: begin
               // SDA rises while SCL is high
               case (phase_reg)
                  2'h0: sda_next = 1'b0;
                  2'h1: scl_next = 1'b1;
                  2'h2: sda_next = 1'b1;
                  default: begin
                     busy_next = 1'b0;
                     done = 1'b1;
                  end
               endcase
            end
            default: begin
               // Data and ack cells; sample SDA in the middle of SCL high
               case (phase_reg)
                  2'h0: sda_next = sh_reg[8];
                  2'h1: scl_next = 1'b1;
                  2'h2: sh_next = {sh_reg[7:0], i_sda};
                  default: begin
                     scl_next = 1'b0;
                     bit_next = bit_reg + 4'h1;
                     if (bit_reg == BITS_LAST) begin
                        busy_next = 1'b0;
                        done = 1'b1;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         qtr_reg <= '0;
         phase_reg <= '0;
         bit_reg <= '0;
         sh_reg <= '0;
         busy_reg <= 1'b0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else if (i_ce) begin
         qtr_reg <= qtr_next;
         phase_reg <= phase_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         busy_reg <= busy_next;
         scl_reg <= scl_next;
         sda_reg <= sda_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; the received byte sits in bits 8:1 after the ack is sampled
   assign bus.cmd_done = done & i_ce;
   assign bus.rx_byte = sh_reg[8:1];
   assign bus.rx_ack_bit = sh_reg[0];
   assign o_scl_oe_n = scl_reg;
   assign o_sda_oe_n = sda_reg;

   a_scl_stable_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $fell(sda_reg) && busy_reg |-> scl_reg || bus.cmd != IWB_CMD_START)
      else $error("start edge without SCL high");
endmodule

// ### tb/iwb_slave_model.sv
// Purpose: Behavioural two-wire slave that answers the byte engine
// Assumes: Open-drain lines with pull-ups resolved in the bench
// Notes: Keeps written bytes and the master's read acknowledges for the bench
`timescale 1ns/100ps
module iwb_slave_model #(
   parameter logic [6:0] SLV_ADDR = 7'h3A
) (
   // Bus lines
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_oe_n,
   // Bytes returned on reads
   input wire logic [7:0] i_rd_byte0,
   input wire logic [7:0] i_rd_byte1
);
   logic [7:0] shift_reg, cur;
   logic sel, rd, mack;
   int cnt, nbyte;
   logic [7:0] wr_q[$];
   logic mack_q[$];
   initial begin
      o_sda_oe_n = 1'b1;
      cnt = 0;
      nbyte = 0;
      sel = 1'b0;
   end
   // Start restarts byte framing; stop drops the selection
   always @(negedge i_sda) begin
      if (i_scl) begin
         cnt = 0;
         nbyte = 0;
         mack = 1'b0;
      end
   end
   always @(posedge i_sda) begin
      if (i_scl) begin
         sel = 1'b0;
      end
   end
   // Rising clock: data cells shift in, on read data bytes the ninth cell holds the master's answer
   always @(posedge i_scl) begin
      if (cnt < 8) shift_reg = {shift_reg[6:0], i_sda};
      else if (sel && rd && nbyte > 0) begin
         mack = i_sda;
         mack_q.push_back(i_sda);
      end
      cnt++;
   end
   // Falling clock: change the line only while the clock is low
   always @(negedge i_scl) begin
      o_sda_oe_n = 1'b1;
      if (cnt == 9) begin
         cnt = 0;
         nbyte++;
      end
      if (cnt == 8 && nbyte == 0) begin
         sel = (shift_reg[7:1] == SLV_ADDR);
         rd = shift_reg[0];
      end
      if (cnt == 8 && sel && !rd && nbyte > 0) wr_q.push_back(shift_reg);
      cur = (nbyte == 1) ? i_rd_byte0 : i_rd_byte1;
      if (cnt == 8 && sel && (!rd || nbyte == 0)) o_sda_oe_n = 1'b0;
      else if (cnt < 8 && sel && rd && nbyte > 0 && !mack) o_sda_oe_n = cur[7 - cnt];
   end
endmodule

// ### tb/tb_i2c_master_byte_engine.sv
// Purpose: Self-checking bench for the two-wire master byte engine
// Assumes: Slave model on open-drain lines with pull-ups
// Notes: Hand-picked frames first, then random ones from a fixed seed
`timescale 1ns/100ps
module tb_i2c_master_byte_engine;
   import iwb_pkg::*;
   localparam logic [6:0] SLV = 7'h3A;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic wr = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] b0 = 8'h00;
   logic [7:0] b1 = 8'h00;
   logic [7:0] rdata;
   logic irq, scl_o, scl_oe_n, sda_o, sda_oe_n, slv_oe_n;
   int fail_count = 0;
   int compares = 0;
   time rise_q[$];
   logic [15:0] regs[6] = '{ADDR_TARGET, ADDR_TX_FIRST, ADDR_TX_SECOND, ADDR_CTRL, ADDR_IRQ6,
                            16'hFF90};
   // Open-drain resolution, pull-ups high
   wire logic scl_w = scl_oe_n ? 1'b1 : scl_o;
   wire logic sda_w = (sda_oe_n ? 1'b1 : sda_o) & slv_oe_n;
   always #10 clk = ~clk;
   always @(posedge scl_w) rise_q.push_back($time);
   iwb_top DUT (.i_ref_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1), .i_sfr_addr(addr),
      .i_sfr_wr(wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_ext_irq6(irq),
      .i_scl(scl_w), .i_sda(sda_w), .o_scl(scl_o), .o_scl_oe_n(scl_oe_n), .o_sda(sda_o),
      .o_sda_oe_n(sda_oe_n));
   iwb_slave_model #(.SLV_ADDR(SLV)) u_slave (.i_scl(scl_w), .i_sda(sda_w),
      .o_sda_oe_n(slv_oe_n), .i_rd_byte0(b0), .i_rd_byte1(b1));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Data bytes a frame carries for a given length bit
   function automatic logic [7:0] exp_bytes(input logic len);
      return {7'h00, len} + 8'h01;
   endfunction
   // Bus cycles: drive just after the edge, hold through the taking edge
   task automatic sfr_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk) #1;
      wr = 1'b0;
   endtask
   task automatic sfr_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      addr = a;
      @(posedge clk) #1;
      d = rdata;
   endtask
   // Poll the busy bit; a bound keeps a stuck frame from hanging the run
   task automatic wait_idle();
      logic [7:0] ctl;
      for (int n = 0; n < 4000; n++) begin
         sfr_rd(ADDR_CTRL, ctl);
         if (ctl[BIT_GO] === 1'b0) return;
      end
      fail_count++;
      $display("ERROR at %0t: frame never finished", $time);
      finish_test();
   endtask
   // One frame with every outcome worked out from its settings
   task automatic run_frame(input logic dir, input logic len, input logic [6:0] sa);
      logic [7:0] v, d0, d1;
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      u_slave.wr_q.delete();
      u_slave.mack_q.delete();
      sfr_wr(ADDR_TARGET, {sa, dir});
      sfr_wr(ADDR_TX_FIRST, d0);
      sfr_wr(ADDR_TX_SECOND, d1);
      sfr_wr(ADDR_CTRL, {6'h00, 1'b1, len});
      rise_q.delete();
      check({7'h00, irq}, 8'h00);
      sfr_rd(ADDR_CTRL, v);
      check(v & 8'h06, 8'h02);
      sfr_wr(ADDR_TX_FIRST, ~d0);
      wait_idle();
      check({7'h00, irq}, 8'h01);
      sfr_rd(ADDR_IRQ6, v);
      check(v, 8'h0C);
      sfr_rd(ADDR_CTRL, v);
      check(v & 8'h06, (sa == SLV) ? 8'h00 : 8'h04);
      check(8'((rise_q[8] - rise_q[0]) / 160), 8'(4 * QTR_CYC));
      if (sa != SLV) check(8'(u_slave.wr_q.size()), 8'h00);
      else if (!dir) begin
         check(8'(u_slave.wr_q.size()), exp_bytes(len));
         check(u_slave.wr_q[0], d0);
         if (len) check(u_slave.wr_q[1], d1);
      end else begin
         sfr_rd(ADDR_RX_FIRST, v);
         check(v, b0);
         sfr_rd(ADDR_RX_SECOND, v);
         if (len) check(v, b1);
         check(8'(u_slave.mack_q.size()), exp_bytes(len));
         check({7'h00, u_slave.mack_q[len]}, 8'h01);
         if (len) check({7'h00, u_slave.mack_q[0]}, 8'h00);
      end
      $display("Frame dir %0b len %0b addr %h finished", dir, len, sa);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v;
      void'($urandom(32'hFDFB));
      repeat (12) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
      // Reset values, unmapped place included
      foreach (regs[i]) begin
         sfr_rd(regs[i], v);
         check(v, RST_BYTE);
      end
      sfr_wr(ADDR_IRQ6, 8'h08);
      sfr_rd(ADDR_IRQ6, v);
      check(v, 8'h08);
      $display("Register test finished");
      for (int i = 0; i < 4; i++) run_frame(i[1], i[0], SLV);
      run_frame(1'b0, 1'b1, SLV ^ 7'h01);
      repeat (3) run_frame(1'($urandom), 1'($urandom), SLV);
      // Masking the enable drops the interrupt line
      sfr_wr(ADDR_IRQ6, 8'h04);
      check({7'h00, irq}, 8'h00);
      sfr_rd(ADDR_IRQ6, v);
      check(v, 8'h04);
      $display("Mask test finished");
      finish_test();
   end
endmodule
